// ---- hw/atm_defines.svh ----
/*
  Constants of the aux and temperature threshold monitor: register offsets,
  field positions, reset values and serial command layout.
  Assumes it is included once per compile unit; the guard makes repeats safe.
*/
`ifndef ATM_DEFINES_SVH
`define ATM_DEFINES_SVH

// register page and offsets
`define ATM_PAGE 4'h1
`define ATM_OFS_SECOND_AUX_INPUT_MAX 6'h0A
`define ATM_OFS_SECOND_AUX_INPUT_MIN 6'h0B
`define ATM_OFS_CFG 6'h0C

// limit register fields
`define ATM_LIM_EN_BIT 12
`define ATM_LIM_FIELD 11:0
`define ATM_MAX_RESET 12'hFFF
`define ATM_MIN_RESET 12'h000

// configuration register fields
`define ATM_CFG_SENSOR_SEL 15
`define ATM_CFG_SECOND_AUX_INPUT_RES 14
`define ATM_CFG_FIRST_AUX_INPUT_RES 13
`define ATM_CFG_AUTO_TEMP 12
`define ATM_CFG_AUTO_FIRST_AUX_INPUT 11
`define ATM_CFG_AUTO_SECOND_AUX_INPUT 10
`define ATM_CFG_PIN_IRQ 9
`define ATM_CFG_FLAGS 8:3
`define ATM_CFG_EXT_BIAS 2
`define ATM_CFG_RESET 1'b0

// converter mode field values that name a temperature sensor
`define ATM_MODE_TEMP_A 4'hA
`define ATM_MODE_TEMP_B 4'hC

// serial command word layout
`define ATM_CMD_READ 15
`define ATM_CMD_PAGE 14:11
`define ATM_CMD_ADDR 10:5
`define ATM_WORD_BITS 6'd16

`endif

// ---- hw/atm_limit_check.sv ----
/*
  One limit comparator: at or above max, at or below min, each gated by
  its own check enable.
  Assumes the code and the limits are stable in the cycle they are used.
*/
`timescale 1ns/100ps
module atm_limit_check #(
  parameter int CODE_W = 12
) (
  // result and limits
  input wire logic [CODE_W-1:0] code,
  input wire atm_pkg::atm_limits_s lim,
  // comparison answers
  output logic at_max,
  output logic at_min
);
  import atm_pkg::*;

  // only twelve-bit codes fit the limit fields; refused at elaboration
  if (CODE_W != 12) begin : g_bad_width
    $error("limit fields are twelve bits wide");
  end

  // a disabled check never reports, so a stale limit cannot raise anything
  assign at_max = lim.max_en && (code >= lim.max_lim);
  assign at_min = lim.min_en && (code <= lim.min_lim);
endmodule

// ---- hw/atm_pkg.sv ----
/*
  Types shared by the threshold monitor files.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package atm_pkg;
  typedef enum logic [1:0] {
    ATM_SRC_TEMP_A = 2'b00,
    ATM_SRC_TEMP_B = 2'b01,
    ATM_SRC_FIRST_AUX_INPUT = 2'b10,
    ATM_SRC_SECOND_AUX_INPUT = 2'b11
  } atm_src_e;

  typedef enum logic [1:0] {
    ATM_PH_CMD = 2'b00,
    ATM_PH_DATA = 2'b01,
    ATM_PH_DONE = 2'b10
  } atm_phase_e;

  typedef struct packed {
    logic valid;
    logic auto_scan;
    atm_src_e src;
    logic [11:0] code;
  } atm_result_s;

  typedef struct packed {
    logic max_en;
    logic [11:0] max_lim;
    logic min_en;
    logic [11:0] min_lim;
  } atm_limits_s;

  typedef struct packed {
    logic auto_temp_en;
    logic temp_sensor_b;
    logic auto_first_aux_input_en;
    logic auto_second_aux_input_en;
    logic first_aux_input_res;
    logic second_aux_input_res;
    logic ext_bias;
  } atm_scan_ctrl_s;

  typedef struct packed {
    logic wr;
    logic [3:0] page;
    logic [5:0] addr;
    logic [15:0] data;
  } atm_reg_req_s;
endpackage

// ---- hw/atm_spi_slave.sv ----
/*
  Host serial port slave: a 16-bit command word (read bit, page, address)
  followed by one 16-bit data word, mode 0, most significant bit first.
  Assumes sclk, cs_n and mosi are synchronous to clk_sys and slower than
  half its rate, so edges are found by comparing with the last sample.
*/
`timescale 1ns/100ps
module atm_spi_slave (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // serial pins
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // register side
  output atm_pkg::atm_reg_req_s req,
  input wire logic [15:0] rd_data
);
  import atm_pkg::*;
  `include "atm_defines.svh"

  logic sclk_q;
  logic [5:0] cnt;
  logic [15:0] shin;
  logic [15:0] cmd;
  logic [15:0] shout;
  atm_phase_e phase;
  logic rise;
  logic fall;
  logic wr_q;
  logic [15:0] data_q;

  assign rise = spi_sclk && !sclk_q;
  assign fall = !spi_sclk && sclk_q;
  assign spi_miso = shout[15];
  assign spi_miso_oe = !spi_cs_n;
  // request is built whole so each field has a single driver
  assign req = '{wr: wr_q, page: cmd[`ATM_CMD_PAGE],
    addr: cmd[`ATM_CMD_ADDR], data: data_q};

  // last clock sample for edge finding
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'b0;
    end else if (ce) begin
      sclk_q <= spi_sclk;
    end
  end

  // bit counter and phase; chip select high aborts any frame
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase <= ATM_PH_CMD;
      cnt <= 6'd0;
      shin <= 16'h0000;
      cmd <= 16'h0000;
    end else if (ce) begin
      if (spi_cs_n) begin
        phase <= ATM_PH_CMD;
        cnt <= 6'd0;
      end else if (rise) begin
        case (phase)
          ATM_PH_CMD: begin
            shin <= {shin[14:0], spi_mosi};
            cnt <= cnt + 6'd1;
            if (cnt == `ATM_WORD_BITS - 6'd1) begin
              cmd <= {shin[14:0], spi_mosi};
              phase <= ATM_PH_DATA;
            end
          end
          ATM_PH_DATA: begin
            shin <= {shin[14:0], spi_mosi};
            cnt <= cnt + 6'd1;
            if (cnt == 6'd31) begin
              phase <= ATM_PH_DONE;
            end
          end
          default: begin
            phase <= ATM_PH_DONE;
          end
        endcase
      end
    end
  end

  // write strobe once the data word is complete
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      data_q <= 16'h0000;
    end else if (ce) begin
      wr_q <= !spi_cs_n && rise && phase == ATM_PH_DATA &&
        cnt == 6'd31 && !cmd[`ATM_CMD_READ];
      if (rise && phase == ATM_PH_DATA && cnt == 6'd31) begin
        data_q <= {shin[14:0], spi_mosi};
      end
    end
  end

  // read data load on the fall after the command, then shift on each fall
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shout <= 16'h0000;
    end else if (ce) begin
      if (spi_cs_n) begin
        shout <= 16'h0000;
      end else if (fall && phase == ATM_PH_DATA) begin
        if (cnt == `ATM_WORD_BITS) begin
          shout <= cmd[`ATM_CMD_READ] ? rd_data : 16'h0000;
        end else begin
          shout <= {shout[14:0], 1'b0};
        end
      end
    end
  end
endmodule

// ---- hw/atm_threshold_monitor.sv ----
/*
  Aux and temperature threshold monitor: aux two limit registers, the
  measurement configuration register with its read-only flags, the limit
  checks and the interrupt routed to general pin one.
  Assumes the converter core delivers one result per valid pulse, and that
  the temperature and aux one limits come from their own registers outside.
*/
`timescale 1ns/100ps
module atm_threshold_monitor #(
  parameter int CODE_W = 12
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // host serial port
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // conversion results and outside limits
  input wire atm_pkg::atm_result_s result,
  input wire atm_pkg::atm_limits_s temp_limits,
  input wire atm_pkg::atm_limits_s first_aux_input_limits,
  input wire logic [3:0] converter_mode_field,
  input wire logic [1:0] pin_route_bits,
  // scan control to the converter core
  output atm_pkg::atm_scan_ctrl_s scan_ctrl,
  // interrupt
  output logic threshold_irq,
  output logic general_pin_one_out,
  output logic general_pin_one_oe
);
  import atm_pkg::*;
  `include "atm_defines.svh"

  // refused at elaboration: register fields are twelve bits
  if (CODE_W != 12) begin : g_bad_width
    $error("monitor serves twelve-bit codes only");
  end

  atm_reg_req_s req;
  logic [15:0] rd_data;
  logic second_aux_max_check_en;
  logic [11:0] second_aux_max_limit;
  logic second_aux_min_check_en;
  logic [11:0] second_aux_min_limit;
  logic temp_sensor_select;
  logic first_aux_resistance_mode;
  logic second_aux_resistance_mode;
  logic auto_temperature_en;
  logic auto_first_aux_en;
  logic auto_second_aux_en;
  logic pin_interrupt_select;
  logic external_bias_select;
  logic temperature_max_flag;
  logic temperature_min_flag;
  logic first_aux_max_flag;
  logic first_aux_min_flag;
  logic second_aux_max_flag;
  logic second_aux_min_flag;
  logic [5:0] next_flags;
  atm_limits_s second_aux_input_limits;
  logic temp_hi, temp_lo, first_aux_input_hi, first_aux_input_lo, second_aux_input_hi, second_aux_input_lo;
  logic temp_sel_b, temp_hit, first_aux_input_hit, second_aux_input_hit;
  logic page_ok;

  atm_spi_slave u_spi (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .req(req),
    .rd_data(rd_data)
  );

  // read image of one register; unmapped and reserved bits read zero
  function automatic logic [15:0] reg_image(input logic [5:0] addr);
    logic [15:0] v;
    v = 16'h0000;
    case (addr)
      `ATM_OFS_SECOND_AUX_INPUT_MAX: begin
        v[`ATM_LIM_EN_BIT] = second_aux_max_check_en;
        v[`ATM_LIM_FIELD] = second_aux_max_limit;
      end
      `ATM_OFS_SECOND_AUX_INPUT_MIN: begin
        v[`ATM_LIM_EN_BIT] = second_aux_min_check_en;
        v[`ATM_LIM_FIELD] = second_aux_min_limit;
      end
      `ATM_OFS_CFG: begin
        v[`ATM_CFG_SENSOR_SEL] = temp_sensor_select;
        v[`ATM_CFG_SECOND_AUX_INPUT_RES] = second_aux_resistance_mode;
        v[`ATM_CFG_FIRST_AUX_INPUT_RES] = first_aux_resistance_mode;
        v[`ATM_CFG_AUTO_TEMP] = auto_temperature_en;
        v[`ATM_CFG_AUTO_FIRST_AUX_INPUT] = auto_first_aux_en;
        v[`ATM_CFG_AUTO_SECOND_AUX_INPUT] = auto_second_aux_en;
        v[`ATM_CFG_PIN_IRQ] = pin_interrupt_select;
        v[`ATM_CFG_FLAGS] = {temperature_max_flag, temperature_min_flag,
          first_aux_max_flag, first_aux_min_flag,
          second_aux_max_flag, second_aux_min_flag};
        v[`ATM_CFG_EXT_BIAS] = external_bias_select;
      end
      default: begin
        v = 16'h0000;
      end
    endcase
    return v;
  endfunction

  assign page_ok = req.page == `ATM_PAGE;
  // other pages answer zero so a stray read is harmless; always_comb also
  // wakes on the register bits the function reads, a plain assign would not
  always_comb begin
    rd_data = 16'h0000;
    if (page_ok) begin
      rd_data = reg_image(req.addr);
    end
  end

  // aux two limit registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      second_aux_max_check_en <= 1'b0;
      second_aux_max_limit <= `ATM_MAX_RESET;
      second_aux_min_check_en <= 1'b0;
      second_aux_min_limit <= `ATM_MIN_RESET;
    end else if (ce && req.wr && page_ok) begin
      if (req.addr == `ATM_OFS_SECOND_AUX_INPUT_MAX) begin
        second_aux_max_check_en <= req.data[`ATM_LIM_EN_BIT];
        second_aux_max_limit <= req.data[`ATM_LIM_FIELD];
      end
      if (req.addr == `ATM_OFS_SECOND_AUX_INPUT_MIN) begin
        second_aux_min_check_en <= req.data[`ATM_LIM_EN_BIT];
        second_aux_min_limit <= req.data[`ATM_LIM_FIELD];
      end
    end
  end

  // configuration bits; flags and reserved bits are not writable
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      temp_sensor_select <= `ATM_CFG_RESET;
      second_aux_resistance_mode <= `ATM_CFG_RESET;
      first_aux_resistance_mode <= `ATM_CFG_RESET;
      auto_temperature_en <= `ATM_CFG_RESET;
      auto_first_aux_en <= `ATM_CFG_RESET;
      auto_second_aux_en <= `ATM_CFG_RESET;
      pin_interrupt_select <= `ATM_CFG_RESET;
      external_bias_select <= `ATM_CFG_RESET;
    end else if (ce && req.wr && page_ok && req.addr == `ATM_OFS_CFG) begin
      temp_sensor_select <= req.data[`ATM_CFG_SENSOR_SEL];
      second_aux_resistance_mode <= req.data[`ATM_CFG_SECOND_AUX_INPUT_RES];
      first_aux_resistance_mode <= req.data[`ATM_CFG_FIRST_AUX_INPUT_RES];
      auto_temperature_en <= req.data[`ATM_CFG_AUTO_TEMP];
      auto_first_aux_en <= req.data[`ATM_CFG_AUTO_FIRST_AUX_INPUT];
      auto_second_aux_en <= req.data[`ATM_CFG_AUTO_SECOND_AUX_INPUT];
      pin_interrupt_select <= req.data[`ATM_CFG_PIN_IRQ];
      external_bias_select <= req.data[`ATM_CFG_EXT_BIAS];
    end
  end

  // scan control straight from the configuration flops
  assign scan_ctrl.auto_temp_en = auto_temperature_en;
  assign scan_ctrl.temp_sensor_b = temp_sensor_select;
  assign scan_ctrl.auto_first_aux_input_en = auto_first_aux_en;
  assign scan_ctrl.auto_second_aux_input_en = auto_second_aux_en;
  assign scan_ctrl.first_aux_input_res = first_aux_resistance_mode;
  assign scan_ctrl.second_aux_input_res = second_aux_resistance_mode;
  assign scan_ctrl.ext_bias = external_bias_select;

  // limit checks
  assign second_aux_input_limits = '{max_en: second_aux_max_check_en,
    max_lim: second_aux_max_limit,
    min_en: second_aux_min_check_en,
    min_lim: second_aux_min_limit};

  atm_limit_check #(.CODE_W(CODE_W)) u_temp_chk (
    .code(result.code),
    .lim(temp_limits),
    .at_max(temp_hi),
    .at_min(temp_lo)
  );

  atm_limit_check #(.CODE_W(CODE_W)) u_first_aux_input_chk (
    .code(result.code),
    .lim(first_aux_input_limits),
    .at_max(first_aux_input_hi),
    .at_min(first_aux_input_lo)
  );

  atm_limit_check #(.CODE_W(CODE_W)) u_second_aux_input_chk (
    .code(result.code),
    .lim(second_aux_input_limits),
    .at_max(second_aux_input_hi),
    .at_min(second_aux_input_lo)
  );

  // which result feeds which flag pair; auto results of a disabled
  // channel are dropped so a late conversion cannot touch the flags
  always_comb begin
    temp_sel_b = result.auto_scan ? temp_sensor_select
      : (converter_mode_field == `ATM_MODE_TEMP_B);
    temp_hit = result.valid &&
      (result.auto_scan ? auto_temperature_en
        : (converter_mode_field == `ATM_MODE_TEMP_A ||
           converter_mode_field == `ATM_MODE_TEMP_B)) &&
      (result.src == (temp_sel_b ? ATM_SRC_TEMP_B : ATM_SRC_TEMP_A));
    first_aux_input_hit = result.valid && result.src == ATM_SRC_FIRST_AUX_INPUT &&
      (!result.auto_scan || auto_first_aux_en);
    second_aux_input_hit = result.valid && result.src == ATM_SRC_SECOND_AUX_INPUT &&
      (!result.auto_scan || auto_second_aux_en);
  end

  // next flag set; each pair only moves on a result of its own input
  always_comb begin
    next_flags = {temperature_max_flag, temperature_min_flag,
      first_aux_max_flag, first_aux_min_flag,
      second_aux_max_flag, second_aux_min_flag};
    if (temp_hit) begin
      next_flags[5:4] = {temp_hi, temp_lo};
    end
    if (first_aux_input_hit) begin
      next_flags[3:2] = {first_aux_input_hi, first_aux_input_lo};
    end
    if (second_aux_input_hit) begin
      next_flags[1:0] = {second_aux_input_hi, second_aux_input_lo};
    end
  end

  // flags hold the outcome of the last result of each input
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      temperature_max_flag <= 1'b0;
      temperature_min_flag <= 1'b0;
      first_aux_max_flag <= 1'b0;
      first_aux_min_flag <= 1'b0;
      second_aux_max_flag <= 1'b0;
      second_aux_min_flag <= 1'b0;
    end else if (ce) begin
      temperature_max_flag <= next_flags[5];
      temperature_min_flag <= next_flags[4];
      first_aux_max_flag <= next_flags[3];
      first_aux_min_flag <= next_flags[2];
      second_aux_max_flag <= next_flags[1];
      second_aux_min_flag <= next_flags[0];
    end
  end

  // interrupt is a level while any input stands outside its limits;
  // pin one is only claimed while the outside routing bits leave it free
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      threshold_irq <= 1'b0;
      general_pin_one_out <= 1'b0;
      general_pin_one_oe <= 1'b0;
    end else if (ce) begin
      threshold_irq <= |next_flags;
      general_pin_one_out <= |next_flags;
      general_pin_one_oe <= pin_interrupt_select &&
        pin_route_bits == 2'b00;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_second_aux_input_max_hit: assert property (
    ce && second_aux_input_hit && second_aux_max_check_en &&
    result.code >= second_aux_max_limit |=> second_aux_max_flag)
    else $error("aux two at max limit did not set its flag");

  a_second_aux_input_max_off: assert property (
    ce && second_aux_input_hit && !second_aux_max_check_en |=> !second_aux_max_flag)
    else $error("disabled aux two max check still set its flag");

  a_second_aux_input_min_hit: assert property (
    ce && second_aux_input_hit && second_aux_min_check_en &&
    result.code <= second_aux_min_limit |=> second_aux_min_flag)
    else $error("aux two at min limit did not set its flag");

  a_second_aux_input_min_off: assert property (
    ce && second_aux_input_hit && !second_aux_min_check_en |=> !second_aux_min_flag)
    else $error("disabled aux two min check still set its flag");

  a_irq_from_flag: assert property (
    ce && second_aux_max_flag |-> ##[0:1] threshold_irq || !ce)
    else $error("flag set without the interrupt");

  a_pin_routed: assert property (
    ce && pin_interrupt_select && pin_route_bits == 2'b00 &&
    $stable(pin_interrupt_select) |=> general_pin_one_oe)
    else $error("pin one not driven while routed");

  a_pin_blocked: assert property (
    ce && pin_route_bits != 2'b00 |=> !general_pin_one_oe)
    else $error("pin one driven while routing bits set");

  a_temp_auto_off: assert property (
    ce && result.valid && result.auto_scan && !auto_temperature_en &&
    !first_aux_input_hit && !second_aux_input_hit |=> $stable(temperature_max_flag))
    else $error("auto temperature disabled but flag moved");

  a_reserved_zero: assert property (
    page_ok && req.addr == `ATM_OFS_CFG |-> rd_data[1:0] == 2'b00)
    else $error("reserved configuration bits read nonzero");
endmodule

// ---- testbench/aux_temp_threshold_monitor_bench.sv ----
/*
  Self-checking bench for the threshold monitor: registers over the serial
  port, limit flags per input, scan gating, sensor choice, pin interrupt.
  Assumes the design files and atm_pkg are compiled first.
*/
`timescale 1ns/100ps
module aux_temp_threshold_monitor_bench;
  import atm_pkg::*;
  logic clk_sys, arst_n, ce, spi_sclk, spi_cs_n, spi_mosi;
  logic spi_miso, spi_miso_oe, threshold_irq, pin_out, pin_oe;
  atm_result_s result;
  atm_limits_s temp_limits, first_aux_input_limits;
  logic [3:0] converter_mode_field;
  logic [1:0] pin_route_bits;
  atm_scan_ctrl_s scan_ctrl;
  int error_cnt, checks_done;
  logic [15:0] cfg, rd, d;
  int pos [8] = '{15, 14, 13, 12, 11, 10, 9, 2};

  atm_threshold_monitor u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .result(result), .temp_limits(temp_limits),
    .first_aux_input_limits(first_aux_input_limits),
    .converter_mode_field(converter_mode_field),
    .pin_route_bits(pin_route_bits), .scan_ctrl(scan_ctrl),
    .threshold_irq(threshold_irq), .general_pin_one_out(pin_out),
    .general_pin_one_oe(pin_oe)
  );

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // inputs always move 1 ns after the edge, never on it
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // one frame: command word then data word, each level held 2 cycles
  task spi(input logic [15:0] cmd, input logic [15:0] dat);
    logic [31:0] bits;
    bits = {cmd, dat};
    spi_cs_n = 1'b0;
    cyc(2);
    for (int i = 31; i >= 0; i--) begin
      spi_mosi = bits[i];
      cyc(2);
      if (i < 16) rd[i] = spi_miso;
      if (i == 0) chk("miso_oe", 16'h0001, {15'h0000, spi_miso_oe});
      spi_sclk = 1'b1;
      cyc(2);
      spi_sclk = 1'b0;
    end
    cyc(2);
    spi_cs_n = 1'b1;
    cyc(4);
    chk("miso_oe", 16'h0000, {15'h0000, spi_miso_oe});
  endtask

  task wr(input logic [5:0] a, input logic [15:0] v);
    spi({1'b0, 4'h1, a, 5'h00}, v);
  endtask

  task rdc(input string n, input logic [3:0] pg, input logic [5:0] a,
           input logic [15:0] e);
    spi({1'b1, pg, a, 5'h00}, 16'h0000);
    chk(n, e, rd);
  endtask

  task wcfg(input logic [15:0] v);
    cfg = v;
    wr(6'h0C, v);
  endtask

  // config readback holds writable bits plus the six flags
  task flags(input logic [5:0] f);
    rdc("config", 4'h1, 6'h0C, (cfg & 16'hFE04) | {7'h00, f, 3'h0});
    chk("irq", {15'h0000, |f}, {15'h0000, threshold_irq});
  endtask

  // one-cycle result pulse, then let the flag update land
  task res(input logic au, input atm_src_e s, input logic [11:0] c);
    result = '{1'b1, au, s, c};
    cyc(1);
    result.valid = 1'b0;
    cyc(2);
  endtask

  task scan(input logic [15:0] v);
    chk("scan_ctrl", {9'h000, v[12], v[15], v[11], v[10], v[13], v[14],
        v[2]}, {9'h000, scan_ctrl});
  endtask

  task test_end(input string n);
    $display("test %s done", n);
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog: the sequence needs about 7800 cycles, well under 30000
  initial begin
    cyc(30000);
    error_cnt++;
    $display("BAD watchdog expected done seen hang");
    summarize;
  end

  // main sequence
  initial begin
    error_cnt = 0;
    checks_done = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    result = '0;
    temp_limits = '0;
    first_aux_input_limits = '0;
    converter_mode_field = 4'h0;
    pin_route_bits = 2'b00;
    cfg = 16'h0000;
    cyc(6);
    arst_n = 1'b1;
    cyc(1);

    // reset values, reserved bits, unmapped places
    rdc("max_reg", 4'h1, 6'h0A, 16'h0FFF);
    rdc("min_reg", 4'h1, 6'h0B, 16'h0000);
    flags(6'h00);
    rdc("unmapped", 4'h1, 6'h0D, 16'h0000);
    wr(6'h0A, 16'hFFFF);
    rdc("max_reg", 4'h1, 6'h0A, 16'h1FFF);
    rdc("other_page", 4'h2, 6'h0A, 16'h0000);
    test_end("registers");

    // every config bit alone, then all ones over the read-only flags
    foreach (pos[k]) begin
      d = 16'h0001 << pos[k];
      wcfg(d);
      scan(d);
      flags(6'h00);
    end
    wcfg(16'hFFFF);
    scan(16'hFFFF);
    flags(6'h00);
    wcfg(16'h0000);
    test_end("config");

    // aux two limits at their boundaries, then with checks disabled
    wr(6'h0A, 16'h1800);
    res(1'b0, ATM_SRC_SECOND_AUX_INPUT, 12'h7FF);
    flags(6'h00);
    res(1'b0, ATM_SRC_SECOND_AUX_INPUT, 12'h800);
    flags(6'h02);
    wr(6'h0A, 16'h0800);
    res(1'b0, ATM_SRC_SECOND_AUX_INPUT, 12'h900);
    flags(6'h00);
    wr(6'h0B, 16'h1100);
    res(1'b0, ATM_SRC_SECOND_AUX_INPUT, 12'h101);
    flags(6'h00);
    res(1'b0, ATM_SRC_SECOND_AUX_INPUT, 12'h100);
    flags(6'h01);
    wr(6'h0B, 16'h0100);
    res(1'b0, ATM_SRC_SECOND_AUX_INPUT, 12'h100);
    flags(6'h00);
    test_end("aux_two");

    // auto results are dropped while their input's auto enable is clear
    wr(6'h0A, 16'h1800);
    res(1'b1, ATM_SRC_SECOND_AUX_INPUT, 12'hFFF);
    flags(6'h00);
    wcfg(16'h0400);
    res(1'b1, ATM_SRC_SECOND_AUX_INPUT, 12'hFFF);
    flags(6'h02);
    first_aux_input_limits = '{1'b1, 12'h800, 1'b1, 12'h100};
    res(1'b1, ATM_SRC_FIRST_AUX_INPUT, 12'h050);
    flags(6'h02);
    wcfg(16'h0C00);
    res(1'b1, ATM_SRC_FIRST_AUX_INPUT, 12'h050);
    flags(6'h06);
    res(1'b0, ATM_SRC_FIRST_AUX_INPUT, 12'h900);
    flags(6'h0A);
    test_end("auto_gating");

    // temperature: auto enable, sensor select, then mode field
    temp_limits = '{1'b1, 12'h800, 1'b1, 12'h100};
    res(1'b1, ATM_SRC_TEMP_A, 12'h900);
    flags(6'h0A);
    wcfg(16'h1C00);
    res(1'b1, ATM_SRC_TEMP_B, 12'h900);
    flags(6'h0A);
    res(1'b1, ATM_SRC_TEMP_A, 12'h900);
    flags(6'h2A);
    wcfg(16'h9C00);
    res(1'b1, ATM_SRC_TEMP_A, 12'h050);
    flags(6'h2A);
    res(1'b1, ATM_SRC_TEMP_B, 12'h050);
    flags(6'h1A);
    converter_mode_field = 4'hA;
    res(1'b0, ATM_SRC_TEMP_B, 12'h900);
    flags(6'h1A);
    res(1'b0, ATM_SRC_TEMP_A, 12'h900);
    flags(6'h2A);
    converter_mode_field = 4'h0;
    res(1'b0, ATM_SRC_TEMP_A, 12'h050);
    flags(6'h2A);
    // a result while the clock enable is low must not move any flag
    ce = 1'b0;
    res(1'b0, ATM_SRC_FIRST_AUX_INPUT, 12'h050);
    ce = 1'b1;
    flags(6'h2A);
    test_end("temperature");

    // interrupt on general pin one, claimed only with route bits clear
    wcfg(16'h9E00);
    chk("pin_oe", 16'h0001, {15'h0000, pin_oe});
    chk("pin_out", 16'h0001, {15'h0000, pin_out});
    pin_route_bits = 2'b10;
    cyc(2);
    chk("pin_oe", 16'h0000, {15'h0000, pin_oe});
    pin_route_bits = 2'b00;
    wcfg(16'h9C00);
    chk("pin_oe", 16'h0000, {15'h0000, pin_oe});
    test_end("pin_interrupt");
    summarize;
  end
endmodule
